// >>> src/uec_pkg.sv
package uec_pkg;
  // I/O register addresses
  localparam logic [7:0] ADDR_CTL_MODE = 8'h12;
  localparam logic [7:0] ADDR_DATA_MODE = 8'h14;
  localparam logic [7:0] ADDR_LINE_CTL = 8'h1F;
  localparam logic [7:0] RST_VAL = 8'h00;

  // Field positions
  localparam int BIT_BUS_ACT = 3;
  localparam int BIT_SETUP = 7;
  localparam int BIT_STALL = 7;
  localparam int BIT_IN = 6;
  localparam int BIT_OUT = 5;
  localparam int BIT_ACKED = 4;

  // Line forcing codes
  localparam logic [2:0] FRC_NONE = 3'h0;
  localparam logic [2:0] FRC_K = 3'h1;
  localparam logic [2:0] FRC_J = 3'h2;
  localparam logic [2:0] FRC_SE0 = 3'h3;

  // Endpoint modes
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_INOUT = 4'h1;
  localparam logic [3:0] MODE_STATUS_OUT = 4'h2;
  localparam logic [3:0] MODE_STALL_INOUT = 4'h3;
  localparam logic [3:0] MODE_IGN_INOUT = 4'h4;
  localparam logic [3:0] MODE_RSV5 = 4'h5;
  localparam logic [3:0] MODE_STATUS_IN = 4'h6;
  localparam logic [3:0] MODE_RSV7 = 4'h7;
  localparam logic [3:0] MODE_NAK_OUT = 4'h8;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_NAK_OUT_ST_IN = 4'hA;
  localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hB;
  localparam logic [3:0] MODE_NAK_IN = 4'hC;
  localparam logic [3:0] MODE_ACK_IN = 4'hD;
  localparam logic [3:0] MODE_NAK_IN_ST_OUT = 4'hE;
  localparam logic [3:0] MODE_ACK_IN_ST_OUT = 4'hF;

  // Token kinds
  localparam logic [1:0] PID_SETUP = 2'h0;
  localparam logic [1:0] PID_IN = 2'h1;
  localparam logic [1:0] PID_OUT = 2'h2;

  // Responses to a token
  localparam logic [2:0] RSP_IGNORE = 3'h0;
  localparam logic [2:0] RSP_ACK = 3'h1;
  localparam logic [2:0] RSP_NAK = 3'h2;
  localparam logic [2:0] RSP_STALL = 3'h3;
  localparam logic [2:0] RSP_TX0 = 3'h4;
  localparam logic [2:0] RSP_TXCNT = 3'h5;
  localparam logic [2:0] RSP_CHECK = 3'h6;

  // FIFO windows in data RAM
  localparam logic [7:0] DATA_FIFO_BASE = 8'hF0;
  localparam logic [7:0] CTL_FIFO_BASE = 8'hF8;
  localparam logic [7:0] FIFO_WIN_MASK = 8'hF0;
  localparam int FIFO_BYTES = 8;
  localparam int FIFO_ENTRIES = 16;
endpackage

// >>> src/uec_fifo_if.sv
`timescale 1ns/1ps
interface uec_fifo_if;
  logic cpu_we;
  logic [3:0] cpu_idx;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic sie_we;
  logic [3:0] sie_idx;
  logic [7:0] sie_wdata;
  logic [7:0] sie_rdata;
  modport ctl (
    output cpu_we, cpu_idx, cpu_wdata, sie_we, sie_idx, sie_wdata,
    input cpu_rdata, sie_rdata
  );
  modport store (
    input cpu_we, cpu_idx, cpu_wdata, sie_we, sie_idx, sie_wdata,
    output cpu_rdata, sie_rdata
  );
endinterface

// >>> src/uec_fifo_store.sv
`timescale 1ns/1ps
module uec_fifo_store (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  uec_fifo_if.store fif
);
  logic [7:0] mem_r [uec_pkg::FIFO_ENTRIES];

  // Entries 0..7 serve the control endpoint, 8..15 the data endpoint
  genvar gi;
  generate
    for (gi = 0; gi < uec_pkg::FIFO_ENTRIES; gi++) begin : g_ent
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          mem_r[gi] <= uec_pkg::RST_VAL;
        end else if (fif.sie_we && fif.sie_idx == 4'(gi)) begin
          // Engine wins a same-byte collision: line data cannot wait
          mem_r[gi] <= fif.sie_wdata;
        end else if (fif.cpu_we && fif.cpu_idx == 4'(gi)) begin
          mem_r[gi] <= fif.cpu_wdata;
        end
      end
    end
  endgenerate

  assign fif.cpu_rdata = mem_r[fif.cpu_idx];
  assign fif.sie_rdata = mem_r[fif.sie_idx];
endmodule

// >>> src/uec_ep_ctl.sv
`timescale 1ns/1ps
module uec_ep_ctl (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic ram_we_i,
  input wire logic [7:0] ram_addr_i,
  input wire logic [7:0] ram_wdata_i,
  output logic [7:0] ram_rdata_o,
  input wire logic bus_activity_i,
  input wire logic tok_valid_i,
  input wire logic tok_ep_i,
  input wire logic [1:0] tok_pid_i,
  output logic resp_valid_o,
  output logic [2:0] resp_o,
  input wire logic xact_done_i,
  input wire logic xact_ack_i,
  input wire logic sie_fifo_we_i,
  input wire logic [3:0] sie_fifo_idx_i,
  input wire logic [7:0] sie_fifo_wdata_i,
  output logic [7:0] sie_fifo_rdata_o,
  input wire logic sie_dp_i,
  input wire logic sie_dm_i,
  input wire logic sie_oe_i,
  output logic dp_o,
  output logic dp_oe_o,
  output logic dm_o,
  output logic dm_oe_o
);
  logic bus_act_r;
  logic [2:0] force_r;
  logic ctl_setup_r, ctl_in_r, ctl_out_r, ctl_ack_r;
  logic [3:0] ctl_mode_r;
  logic data_stall_r, data_in_r, data_out_r, data_ack_r;
  logic [3:0] data_mode_r;
  logic tok_ep_r;
  logic [1:0] tok_pid_r;
  logic ctl_busy_r;
  logic wr_line, wr_ctl, wr_data, ctl_wr_ok;
  logic done_ack, done_ctl, done_data, ram_hit;
  logic [3:0] cur_mode, ctl_mode_nxt, data_mode_nxt;
  logic [2:0] resp_nxt;

  uec_fifo_if fif ();

  uec_fifo_store u_store (
    .mclk_i (mclk_i),
    .rst_n_i (rst_n_i),
    .fif (fif)
  );

  assign wr_line = io_wr_i && io_addr_i == uec_pkg::ADDR_LINE_CTL;
  assign wr_ctl = io_wr_i && io_addr_i == uec_pkg::ADDR_CTL_MODE;
  assign wr_data = io_wr_i && io_addr_i == uec_pkg::ADDR_DATA_MODE;
  // Locked while a control transaction is in flight, so firmware cannot
  // wipe a SETUP flag the engine is about to raise
  assign ctl_wr_ok = wr_ctl && !ctl_busy_r;
  assign done_ack = xact_done_i && xact_ack_i;
  assign done_ctl = xact_done_i && !tok_ep_r;
  assign done_data = xact_done_i && tok_ep_r;
  assign ram_hit = (ram_addr_i & uec_pkg::FIFO_WIN_MASK) == uec_pkg::DATA_FIFO_BASE;

  // FIFO access: RAM F0-F7 maps to entries 8..15 (data endpoint)
  assign fif.cpu_idx = {~ram_addr_i[3], ram_addr_i[2:0]};
  assign fif.cpu_wdata = ram_wdata_i;
  assign fif.cpu_we = ram_we_i && ram_hit && (ram_addr_i[3] == 1'b0 || !ctl_setup_r);
  assign fif.sie_we = sie_fifo_we_i;
  assign fif.sie_idx = sie_fifo_idx_i;
  assign fif.sie_wdata = sie_fifo_wdata_i;

  // Bus activity flag: set wins over the clearing write
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bus_act_r <= 1'b0;
    end else if (bus_activity_i) begin
      bus_act_r <= 1'b1;
    end else if (wr_line && !io_wdata_i[uec_pkg::BIT_BUS_ACT]) begin
      bus_act_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      force_r <= uec_pkg::FRC_NONE;
    end else if (wr_line) begin
      force_r <= io_wdata_i[2:0];
    end
  end

  // Line driver
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dp_o <= 1'b0;
      dm_o <= 1'b0;
      dp_oe_o <= 1'b0;
      dm_oe_o <= 1'b0;
    end else if (force_r == uec_pkg::FRC_NONE) begin
      dp_o <= sie_dp_i;
      dm_o <= sie_dm_i;
      dp_oe_o <= sie_oe_i;
      dm_oe_o <= sie_oe_i;
    end else if (!force_r[2]) begin
      dp_o <= force_r == uec_pkg::FRC_K;
      dm_o <= force_r == uec_pkg::FRC_J;
      dp_oe_o <= 1'b1;
      dm_oe_o <= 1'b1;
    end else begin
      // Open-drain: only ever pull low, release by dropping the enable
      dp_o <= 1'b0;
      dm_o <= 1'b0;
      dp_oe_o <= ~force_r[0];
      dm_oe_o <= ~force_r[1];
    end
  end

  // Token capture and control endpoint lock
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tok_ep_r <= 1'b0;
      tok_pid_r <= uec_pkg::PID_SETUP;
      ctl_busy_r <= 1'b0;
    end else begin
      if (tok_valid_i) begin
        tok_ep_r <= tok_ep_i;
        tok_pid_r <= tok_pid_i;
      end
      if (tok_valid_i && !tok_ep_i) begin
        ctl_busy_r <= 1'b1;
      end else if (xact_done_i) begin
        ctl_busy_r <= 1'b0;
      end
    end
  end

  // Token response from the mode table
  always_comb begin
    cur_mode = tok_ep_i ? data_mode_r : ctl_mode_r;
    resp_nxt = uec_pkg::RSP_IGNORE;
    unique case (cur_mode)
      uec_pkg::MODE_DISABLE: resp_nxt = uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_NAK_INOUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                uec_pkg::RSP_ACK : uec_pkg::RSP_NAK;
      uec_pkg::MODE_STATUS_OUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                 uec_pkg::RSP_ACK : (tok_pid_i == uec_pkg::PID_IN) ?
                                 uec_pkg::RSP_STALL : uec_pkg::RSP_CHECK;
      uec_pkg::MODE_STALL_INOUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                  uec_pkg::RSP_ACK : uec_pkg::RSP_STALL;
      uec_pkg::MODE_IGN_INOUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                uec_pkg::RSP_ACK : uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_RSV5: resp_nxt = (tok_pid_i == uec_pkg::PID_OUT) ?
                           uec_pkg::RSP_ACK : uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_STATUS_IN: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                uec_pkg::RSP_ACK : (tok_pid_i == uec_pkg::PID_IN) ?
                                uec_pkg::RSP_TX0 : uec_pkg::RSP_STALL;
      uec_pkg::MODE_RSV7: resp_nxt = (tok_pid_i == uec_pkg::PID_IN) ?
                           uec_pkg::RSP_TXCNT : uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_NAK_OUT: resp_nxt = (tok_pid_i == uec_pkg::PID_OUT) ?
                              uec_pkg::RSP_NAK : uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_ACK_OUT: resp_nxt = (tok_pid_i != uec_pkg::PID_OUT) ?
                              uec_pkg::RSP_IGNORE : (tok_ep_i && data_stall_r) ?
                              uec_pkg::RSP_STALL : uec_pkg::RSP_ACK;
      uec_pkg::MODE_NAK_OUT_ST_IN: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                    uec_pkg::RSP_ACK : (tok_pid_i == uec_pkg::PID_IN) ?
                                    uec_pkg::RSP_TX0 : uec_pkg::RSP_NAK;
      uec_pkg::MODE_ACK_OUT_NAK_IN: resp_nxt = (tok_pid_i == uec_pkg::PID_IN) ?
                                     uec_pkg::RSP_NAK : uec_pkg::RSP_ACK;
      uec_pkg::MODE_NAK_IN: resp_nxt = (tok_pid_i == uec_pkg::PID_IN) ?
                             uec_pkg::RSP_NAK : uec_pkg::RSP_IGNORE;
      uec_pkg::MODE_ACK_IN: resp_nxt = (tok_pid_i != uec_pkg::PID_IN) ?
                             uec_pkg::RSP_IGNORE : (tok_ep_i && data_stall_r) ?
                             uec_pkg::RSP_STALL : uec_pkg::RSP_TXCNT;
      uec_pkg::MODE_NAK_IN_ST_OUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                    uec_pkg::RSP_ACK : (tok_pid_i == uec_pkg::PID_IN) ?
                                    uec_pkg::RSP_NAK : uec_pkg::RSP_CHECK;
      uec_pkg::MODE_ACK_IN_ST_OUT: resp_nxt = (tok_pid_i == uec_pkg::PID_SETUP) ?
                                    uec_pkg::RSP_ACK : (tok_pid_i == uec_pkg::PID_IN) ?
                                    uec_pkg::RSP_TXCNT : uec_pkg::RSP_CHECK;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_o <= uec_pkg::RSP_IGNORE;
    end else begin
      resp_valid_o <= tok_valid_i;
      if (tok_valid_i) begin
        resp_o <= resp_nxt;
      end
    end
  end

  // Automatic mode changes after an ACK handshake
  function automatic logic [3:0] auto_mode(input logic [3:0] m, input logic [1:0] pid,
                                           input logic is_ctl);
    logic [3:0] r;
    r = m;
    if (pid == uec_pkg::PID_SETUP && is_ctl && m != uec_pkg::MODE_DISABLE) begin
      r = uec_pkg::MODE_NAK_INOUT;
    end else if (pid == uec_pkg::PID_OUT && m == uec_pkg::MODE_ACK_OUT_NAK_IN) begin
      r = uec_pkg::MODE_NAK_INOUT;
    end else if (pid == uec_pkg::PID_OUT && m == uec_pkg::MODE_ACK_OUT) begin
      r = uec_pkg::MODE_NAK_OUT;
    end else if (pid == uec_pkg::PID_IN && m == uec_pkg::MODE_ACK_IN) begin
      r = uec_pkg::MODE_NAK_IN;
    end else if (pid == uec_pkg::PID_IN && m == uec_pkg::MODE_ACK_IN_ST_OUT) begin
      r = uec_pkg::MODE_NAK_IN_ST_OUT;
    end
    return r;
  endfunction

  assign ctl_mode_nxt = auto_mode(ctl_mode_r, tok_pid_r, 1'b1);
  assign data_mode_nxt = auto_mode(data_mode_r, tok_pid_r, 1'b0);

  // Control endpoint mode register; engine updates beat firmware writes
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctl_setup_r <= 1'b0;
      ctl_in_r <= 1'b0;
      ctl_out_r <= 1'b0;
      ctl_ack_r <= 1'b0;
      ctl_mode_r <= uec_pkg::MODE_DISABLE;
    end else begin
      if (ctl_wr_ok) begin
        ctl_setup_r <= 1'b0;
        ctl_in_r <= 1'b0;
        ctl_out_r <= 1'b0;
        ctl_ack_r <= io_wdata_i[uec_pkg::BIT_ACKED];
        ctl_mode_r <= io_wdata_i[3:0];
      end
      if (done_ctl && done_ack) begin
        ctl_ack_r <= 1'b1;
        ctl_mode_r <= ctl_mode_nxt;
        if (tok_pid_r == uec_pkg::PID_SETUP) begin
          ctl_setup_r <= 1'b1;
        end
      end
      if (done_ctl && tok_pid_r == uec_pkg::PID_IN) begin
        ctl_in_r <= 1'b1;
      end
      if (done_ctl && tok_pid_r == uec_pkg::PID_OUT) begin
        ctl_out_r <= 1'b1;
      end
    end
  end

  // Data endpoint mode register; writes are never locked, but engine updates beat them
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      data_stall_r <= 1'b0;
      data_in_r <= 1'b0;
      data_out_r <= 1'b0;
      data_ack_r <= 1'b0;
      data_mode_r <= uec_pkg::MODE_DISABLE;
    end else begin
      if (wr_data) begin
        data_stall_r <= io_wdata_i[uec_pkg::BIT_STALL];
        data_in_r <= 1'b0;
        data_out_r <= 1'b0;
        data_ack_r <= io_wdata_i[uec_pkg::BIT_ACKED];
        data_mode_r <= io_wdata_i[3:0];
      end
      if (done_data && done_ack) begin
        data_ack_r <= 1'b1;
        data_mode_r <= data_mode_nxt;
      end
      if (done_data && tok_pid_r == uec_pkg::PID_IN) begin
        data_in_r <= 1'b1;
      end
      if (done_data && tok_pid_r == uec_pkg::PID_OUT) begin
        data_out_r <= 1'b1;
      end
    end
  end

  // Read paths; in/out flags of the data endpoint are internal only
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      io_rdata_o <= uec_pkg::RST_VAL;
      ram_rdata_o <= uec_pkg::RST_VAL;
      sie_fifo_rdata_o <= uec_pkg::RST_VAL;
    end else begin
      sie_fifo_rdata_o <= fif.sie_rdata;
      ram_rdata_o <= ram_hit ? fif.cpu_rdata : uec_pkg::RST_VAL;
      if (io_rd_i) begin
        unique case (io_addr_i)
          uec_pkg::ADDR_LINE_CTL: io_rdata_o <= {4'h0, bus_act_r, force_r};
          uec_pkg::ADDR_CTL_MODE: io_rdata_o <= {ctl_setup_r, ctl_in_r, ctl_out_r,
                                                 ctl_ack_r, ctl_mode_r};
          uec_pkg::ADDR_DATA_MODE: io_rdata_o <= {data_stall_r, 2'h0, data_ack_r,
                                                  data_mode_r};
          default: io_rdata_o <= uec_pkg::RST_VAL;
        endcase
      end
    end
  end

  sequence s_out_ack_in(logic [3:0] m);
    done_data && xact_ack_i && tok_pid_r == uec_pkg::PID_OUT && data_mode_r == m
      && !wr_data;
  endsequence

  a_act_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    bus_act_r && !(wr_line && !io_wdata_i[uec_pkg::BIT_BUS_ACT]) |=> bus_act_r)
    else $error("activity flag dropped");
  a_act_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_line && !io_wdata_i[uec_pkg::BIT_BUS_ACT] && !bus_activity_i |=> !bus_act_r)
    else $error("activity flag not cleared");
  a_act_noset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !bus_act_r && !bus_activity_i |=> !bus_act_r)
    else $error("activity flag set without activity");
  a_force_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    force_r == uec_pkg::FRC_NONE |=> dp_o == $past(sie_dp_i) && dm_oe_o == $past(sie_oe_i))
    else $error("engine lost the line");
  a_force_usb: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    force_r == uec_pkg::FRC_J |=> !dp_o && dm_o && dp_oe_o && dm_oe_o)
    else $error("J not driven");
  a_force_od: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    force_r[2] |=> !dp_o && !dm_o && dp_oe_o == !$past(force_r[0]))
    else $error("open drain wrong");
  a_fifo_lock: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ctl_setup_r && ram_we_i && ram_hit && ram_addr_i[3] |-> !fif.cpu_we)
    else $error("control FIFO written while locked");
  a_setup_clr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !tok_valid_i && ctl_wr_ok && !done_ctl ##1 !tok_valid_i [*2] |-> !ctl_setup_r)
    else $error("SETUP flag survived write");
  a_ack_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_ack |=> (tok_ep_r ? data_ack_r : ctl_ack_r))
    else $error("acked flag missing");
  a_nak_mode: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tok_valid_i && (tok_ep_i ? data_mode_r : ctl_mode_r) == uec_pkg::MODE_NAK_INOUT
      && tok_pid_i != uec_pkg::PID_SETUP |=> resp_valid_o && resp_o == uec_pkg::RSP_NAK)
    else $error("NAK mode did not NAK");
  a_mode_1011: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_out_ack_in(uec_pkg::MODE_ACK_OUT_NAK_IN) |=> data_mode_r == uec_pkg::MODE_NAK_INOUT)
    else $error("1011 did not revert");
  a_mode_1001: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_out_ack_in(uec_pkg::MODE_ACK_OUT) |=> data_mode_r == uec_pkg::MODE_NAK_OUT)
    else $error("1001 did not revert");
  a_other_ep: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_ack && tok_ep_r && !ctl_wr_ok |=> $stable(ctl_mode_r) && $stable(ctl_ack_r))
    else $error("wrong endpoint updated");
endmodule

// >>> bench/uec_host_model.sv
`timescale 1ns/1ps
module uec_host_model (
  input wire logic mclk_i,
  input wire logic resp_valid_i,
  input wire logic [2:0] resp_i,
  output logic bus_activity_o,
  output logic tok_valid_o,
  output logic tok_ep_o,
  output logic [1:0] tok_pid_o,
  output logic xact_done_o,
  output logic xact_ack_o
);
  initial begin
    bus_activity_o = 1'b0;
    tok_valid_o = 1'b0;
    tok_ep_o = 1'b0;
    tok_pid_o = 2'h3;
    xact_done_o = 1'b0;
    xact_ack_o = 1'b0;
  end

  // Token, answer one cycle later, then completion after a prompt or slow gap
  task automatic xfer(input logic ep, input logic [1:0] pid, input logic ack, input int gap,
    output logic [2:0] rsp);
    @(negedge mclk_i);
    tok_valid_o = 1'b1;
    tok_ep_o = ep;
    tok_pid_o = pid;
    @(negedge mclk_i);
    tok_valid_o = 1'b0;
    // Stale qualifiers are inverted so nothing can lean on their last value
    tok_ep_o = ~ep;
    tok_pid_o = ~pid;
    rsp = resp_valid_i ? resp_i : 3'h7;
    repeat (gap) @(negedge mclk_i);
    xact_done_o = 1'b1;
    xact_ack_o = ack;
    @(negedge mclk_i);
    xact_done_o = 1'b0;
    xact_ack_o = ~ack;
  endtask

  task automatic activity();
    @(negedge mclk_i);
    bus_activity_o = 1'b1;
    @(negedge mclk_i);
    bus_activity_o = 1'b0;
  endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] CTL = uec_pkg::ADDR_CTL_MODE;
  localparam logic [7:0] DAT = uec_pkg::ADDR_DATA_MODE;
  localparam logic [7:0] LINE = uec_pkg::ADDR_LINE_CTL;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  logic ram_we_i = 1'b0;
  logic [7:0] ram_addr_i = 8'h00;
  logic [7:0] ram_wdata_i = 8'h00;
  logic [7:0] ram_rdata_o;
  logic bus_activity_i, tok_valid_i, tok_ep_i, xact_done_i, xact_ack_i, resp_valid_o;
  logic [1:0] tok_pid_i;
  logic [2:0] resp_o;
  logic [2:0] rsp;
  logic [3:0] sie_fifo_idx_i = 4'hB;
  logic sie_fifo_we_i = 1'b0;
  logic [7:0] sie_fifo_wdata_i = 8'h00;
  logic [7:0] sie_fifo_rdata_o;
  logic sie_dp_i = 1'b1;
  logic sie_dm_i = 1'b0;
  logic sie_oe_i = 1'b1;
  logic dp_o, dp_oe_o, dm_o, dm_oe_o;
  int n_mismatch = 0;
  int check_count = 0;
  // Pin view is {dp_oe, dp, dm_oe, dm}; released lines are masked off
  logic [2:0] frc_code [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6, 3'h0};
  logic [3:0] frc_exp [9] = '{4'hE, 4'hE, 4'hB, 4'hA, 4'h0, 4'hA, 4'h2, 4'h8, 4'h0};
  logic [3:0] frc_mask [9] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hA, 4'hF, 4'hB, 4'hE, 4'hA};
  // Answers per mode to SETUP, IN and OUT on the control endpoint
  logic [2:0] rsp_setup [16] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h0,
    3'h0, 3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 3'h1, 3'h1};
  logic [2:0] rsp_in [16] = '{3'h0, 3'h2, 3'h3, 3'h3, 3'h0, 3'h0, 3'h4, 3'h5,
    3'h0, 3'h0, 3'h4, 3'h2, 3'h2, 3'h5, 3'h2, 3'h5};
  logic [2:0] rsp_out [16] = '{3'h0, 3'h2, 3'h6, 3'h3, 3'h0, 3'h1, 3'h3, 3'h0,
    3'h2, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h6, 3'h6};

  always #12.5 mclk_i = ~mclk_i;

  uec_ep_ctl i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .ram_we_i(ram_we_i), .ram_addr_i(ram_addr_i), .ram_wdata_i(ram_wdata_i),
    .ram_rdata_o(ram_rdata_o), .bus_activity_i(bus_activity_i), .tok_valid_i(tok_valid_i),
    .tok_ep_i(tok_ep_i), .tok_pid_i(tok_pid_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o),
    .xact_done_i(xact_done_i), .xact_ack_i(xact_ack_i), .sie_fifo_we_i(sie_fifo_we_i),
    .sie_fifo_idx_i(sie_fifo_idx_i), .sie_fifo_wdata_i(sie_fifo_wdata_i),
    .sie_fifo_rdata_o(sie_fifo_rdata_o), .sie_dp_i(sie_dp_i), .sie_dm_i(sie_dm_i),
    .sie_oe_i(sie_oe_i), .dp_o(dp_o), .dp_oe_o(dp_oe_o), .dm_o(dm_o), .dm_oe_o(dm_oe_o)
  );

  uec_host_model i_host (
    .mclk_i(mclk_i), .resp_valid_i(resp_valid_o), .resp_i(resp_o),
    .bus_activity_o(bus_activity_i), .tok_valid_o(tok_valid_i), .tok_ep_o(tok_ep_i),
    .tok_pid_o(tok_pid_i), .xact_done_o(xact_done_i), .xact_ack_o(xact_ack_i)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic io_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk_i);
    io_wr_i = 1'b1;
    io_addr_i = addr;
    io_wdata_i = data;
    @(negedge mclk_i);
    io_wr_i = 1'b0;
  endtask

  task automatic io_rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge mclk_i);
    io_rd_i = 1'b1;
    io_addr_i = addr;
    @(negedge mclk_i);
    io_rd_i = 1'b0;
    @(negedge mclk_i);
    check(io_rdata_o, exp);
  endtask

  task automatic ram_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk_i);
    ram_we_i = 1'b1;
    ram_addr_i = addr;
    ram_wdata_i = data;
    @(negedge mclk_i);
    ram_we_i = 1'b0;
  endtask

  task automatic ram_rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge mclk_i);
    ram_addr_i = addr;
    repeat (2) @(negedge mclk_i);
    check(ram_rdata_o, exp);
  endtask

  task automatic tok(input logic ep, input logic [1:0] pid, input logic ack, input int gap,
    input logic [2:0] exp);
    i_host.xfer(ep, pid, ack, gap, rsp);
    check({5'h00, rsp}, {5'h00, exp});
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    final_report();
  end

  initial begin
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    io_rd(DAT, uec_pkg::RST_VAL);
    io_rd(CTL, 8'h00);
    io_rd(LINE, 8'h00);
    io_wr(LINE, 8'h08);
    io_rd(LINE, 8'h00);
    i_host.activity();
    io_rd(LINE, 8'h08);
    io_wr(LINE, 8'h08);
    io_rd(LINE, 8'h08);
    io_wr(LINE, 8'h00);
    io_rd(LINE, 8'h00);
    // Release-all code goes before the other open-drain codes
    for (int i = 0; i < 9; i++) begin
      if (i == 8) begin
        sie_oe_i = 1'b0;
      end
      io_wr(LINE, {5'h00, frc_code[i]});
      @(negedge mclk_i);
      check({4'h0, {dp_oe_o, dp_o, dm_oe_o, dm_o} & frc_mask[i]}, {4'h0, frc_exp[i]});
    end
    io_wr(DAT, 8'h01);
    tok(1'b1, uec_pkg::PID_IN, 1'b0, 0, uec_pkg::RSP_NAK);
    tok(1'b1, uec_pkg::PID_OUT, 1'b0, 3, uec_pkg::RSP_NAK);
    io_wr(CTL, 8'h01);
    tok(1'b0, uec_pkg::PID_SETUP, 1'b1, 2, uec_pkg::RSP_ACK);
    io_rd(CTL, 8'h91);
    // Engine lands setup data; the locked CPU write must not overwrite it
    @(negedge mclk_i);
    sie_fifo_idx_i = 4'h0;
    sie_fifo_wdata_i = 8'hC3;
    sie_fifo_we_i = 1'b1;
    @(negedge mclk_i);
    sie_fifo_we_i = 1'b0;
    sie_fifo_idx_i = 4'hB;
    ram_wr(8'hF8, 8'h5A);
    ram_rd(8'hF8, 8'hC3);
    ram_wr(8'hF3, 8'hA5);
    ram_rd(8'hF3, 8'hA5);
    check(sie_fifo_rdata_o, 8'hA5);
    io_wr(CTL, 8'h00);
    io_rd(CTL, 8'h00);
    ram_wr(8'hF8, 8'h5A);
    ram_rd(8'hF8, 8'h5A);
    tok(1'b0, uec_pkg::PID_SETUP, 1'b0, 1, uec_pkg::RSP_IGNORE);
    io_rd(CTL, 8'h00);
    io_wr(CTL, 8'h0B);
    tok(1'b0, uec_pkg::PID_OUT, 1'b1, 1, uec_pkg::RSP_ACK);
    io_rd(CTL, 8'h31);
    io_rd(DAT, 8'h01);
    io_wr(CTL, 8'h0D);
    tok(1'b0, uec_pkg::PID_IN, 1'b1, 2, uec_pkg::RSP_TXCNT);
    io_rd(CTL, 8'h5C);
    io_wr(DAT, 8'h09);
    tok(1'b1, uec_pkg::PID_OUT, 1'b1, 0, uec_pkg::RSP_ACK);
    io_rd(DAT, 8'h18);
    io_rd(CTL, 8'h5C);
    io_wr(DAT, 8'h8D);
    tok(1'b1, uec_pkg::PID_IN, 1'b0, 2, uec_pkg::RSP_STALL);
    io_rd(DAT, 8'h8D);
    io_wr(DAT, 8'h89);
    tok(1'b1, uec_pkg::PID_OUT, 1'b0, 1, uec_pkg::RSP_STALL);
    // No handshake, so every mode stays put while all three token kinds are tried
    for (int m = 0; m < 16; m++) begin
      io_wr(CTL, {4'h0, 4'(m)});
      tok(1'b0, uec_pkg::PID_SETUP, 1'b0, 0, rsp_setup[m]);
      tok(1'b0, uec_pkg::PID_IN, 1'b0, 0, rsp_in[m]);
      tok(1'b0, uec_pkg::PID_OUT, 1'b0, 0, rsp_out[m]);
    end
    // Data register write lands while a control transfer is open; control write is refused
    io_wr(CTL, 8'h01);
    fork
      tok(1'b0, uec_pkg::PID_SETUP, 1'b1, 6, uec_pkg::RSP_ACK);
      begin
        io_wr(DAT, 8'h0C);
        io_wr(CTL, 8'h00);
      end
    join
    io_rd(DAT, 8'h0C);
    io_rd(CTL, 8'h91);
    io_wr(DAT, 8'h0B);
    tok(1'b1, uec_pkg::PID_OUT, 1'b1, 0, uec_pkg::RSP_ACK);
    io_rd(DAT, 8'h11);
    final_report();
  end
endmodule
